// >>> rtl/usb_bd_transaction_engine.sv
// Descriptor-driven USB device transaction engine with AXI4-Lite registers.
// Assumes a serial interface engine on aclk that decodes tokens and bytes.
`timescale 1ns/1ps
module usb_bd_transaction_engine
  import usb_bd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic tok_valid,
  input wire logic [3:0] tok_pid,
  input wire logic [2:0] tok_ep,
  input wire logic tok_odd,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_end,
  output logic hs_valid,
  output logic [1:0] hs_code,
  input wire logic sof_valid,
  input wire logic [10:0] sof_frame
);

  eng_state_t st_ff, nxt_st;
  logic [3:0] pid_ff, nxt_pid;
  logic [2:0] ep_ff, nxt_ep;
  logic dir_ff, nxt_dir, odd_ff, nxt_odd;
  logic [1:0] cnt_ff, nxt_cnt;
  logic [7:0] bd0_ff, nxt_bd0, bc_ff, nxt_bc, num_ff, nxt_num;
  logic [5:0] adr_ff, nxt_adr;
  logic over_ff, nxt_over, lat_ff, nxt_lat, endp_ff, nxt_endp;
  logic [7:0] txd_ff, nxt_txd;
  logic txv_ff, nxt_txv, txe_ff, nxt_txe;
  logic hsv_ff, nxt_hsv;
  logic [1:0] hsc_ff, nxt_hsc;
  logic [7:0] stat_ff, nxt_stat;
  logic [10:0] frame_ff, nxt_frame;
  logic [RAM_AW-1:0] a_addr, base, bufp;
  logic [4:0] idx;
  logic a_we, stall_hit, iso_hit;
  logic [7:0] a_wdata, a_rdata;
  logic [INT_W-1:0] int_set, int_clr, int_flags;
  logic [ERR_W-1:0] err_set, err_clr, err_flags;

  // Bus-side state
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr, araddr_ff, nxt_araddr;
  logic [31:0] wdat_ff, nxt_wdat, rd_ff, nxt_rd;
  logic wstb_ff, nxt_wstb, awf_ff, nxt_awf, wf_ff, nxt_wf;
  logic awr_ff, nxt_awr, wr_ff, nxt_wr, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic arr_ff, nxt_arr;
  logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr, rph_ff, nxt_rph;
  logic [ERR_W-1:0] err_en_ff, nxt_err_en;
  logic [6:0] maxp_ff, nxt_maxp;
  logic [7:0] iso_ff, nxt_iso, ep_stall_ff, nxt_ep_stall;
  logic b_we;
  logic [RAM_AW-1:0] b_waddr, b_raddr;
  logic [7:0] b_wdata, b_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  packet_ram #(.AW(RAM_AW), .DW(8)) u_ram (
    .aclk(aclk),
    .a_addr(a_addr),
    .a_we(a_we),
    .a_wdata(a_wdata),
    .a_rdata(a_rdata),
    .b_raddr(b_raddr),
    .b_rdata(b_rdata),
    .b_we(b_we),
    .b_waddr(b_waddr),
    .b_wdata(b_wdata)
  );

  event_flags #(.W(INT_W)) u_int_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(int_set),
    .clr(int_clr),
    .flags(int_flags)
  );

  event_flags #(.W(ERR_W)) u_err_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(err_set),
    .clr(err_clr),
    .flags(err_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor and buffer addressing

  assign idx = {ep_ff, dir_ff, odd_ff};
  assign base = TABLE_BASE + RAM_AW'({idx, 1'b0}) + RAM_AW'(idx);
  assign bufp = {adr_ff, {BUF_ALIGN_BITS{1'b0}}} + RAM_AW'(num_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Transaction engine

  // Next state of the token sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_pid = pid_ff;
    nxt_ep = ep_ff;
    nxt_dir = dir_ff;
    nxt_odd = odd_ff;
    nxt_cnt = cnt_ff;
    nxt_bd0 = bd0_ff;
    nxt_bc = bc_ff;
    nxt_adr = adr_ff;
    nxt_num = num_ff;
    nxt_over = over_ff;
    nxt_lat = lat_ff;
    nxt_endp = endp_ff;
    nxt_txd = txd_ff;
    nxt_txv = txv_ff;
    nxt_txe = 1'b0;
    nxt_hsv = 1'b0;
    nxt_hsc = hsc_ff;
    nxt_stat = stat_ff;
    nxt_frame = frame_ff;
    int_set = '0;
    err_set = '0;
    a_addr = base;
    a_we = 1'b0;
    a_wdata = 8'h00;
    stall_hit = bd0_ff[BD_STALL_BIT] | ep_stall_ff[ep_ff];
    iso_hit = iso_ff[ep_ff];
    if (sof_valid) begin
      nxt_frame = sof_frame;
      int_set[INT_SOF_BIT] = 1'b1;
    end
    // Bytes arriving before the buffer is known cannot be stored
    if ((st_ff == ST_FETCH || st_ff == ST_DECIDE) && !dir_ff) begin
      if (rx_valid) begin
        nxt_lat = 1'b1;
      end
      if (rx_end) begin
        nxt_endp = 1'b1;
      end
    end
    case (st_ff)
      ST_IDLE: begin
        if (tok_valid) begin
          nxt_pid = tok_pid;
          nxt_ep = tok_ep;
          nxt_dir = (tok_pid == PID_IN);
          nxt_odd = tok_odd;
          nxt_cnt = 2'h0;
          nxt_num = 8'h00;
          nxt_over = 1'b0;
          nxt_lat = 1'b0;
          nxt_endp = 1'b0;
          nxt_st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        a_addr = base + RAM_AW'(cnt_ff);
        nxt_cnt = cnt_ff + 2'h1;
        case (cnt_ff)
          2'h1: nxt_bd0 = a_rdata;
          2'h2: nxt_bc = a_rdata;
          2'h3: nxt_adr = a_rdata[7:2];
          default: ;
        endcase
        if (cnt_ff == 2'h3) begin
          nxt_st = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        nxt_st = ST_IDLE;
        nxt_hsv = !iso_hit;
        if (stall_hit) begin
          nxt_hsc = HS_STALL;
        end else if (!bd0_ff[BD_OWN_BIT]) begin
          nxt_hsc = HS_NAK;
        end else begin
          nxt_hsv = 1'b0;
          nxt_st = dir_ff ? ST_TX_RD : ST_RX;
        end
      end
      ST_RX: begin
        a_addr = bufp;
        if (rx_valid) begin
          if (num_ff < {1'b0, maxp_ff}) begin
            a_we = 1'b1;
            a_wdata = rx_data;
            nxt_num = num_ff + 8'h01;
          end else begin
            nxt_over = 1'b1;
          end
        end
        if (rx_end || endp_ff) begin
          if (lat_ff) begin
            nxt_hsv = !iso_hit;
            nxt_hsc = HS_NAK;
            err_set[ERR_TIMEOUT_BIT] = 1'b1;
            nxt_st = ST_IDLE;
          end else begin
            nxt_st = ST_WB0;
          end
        end
      end
      ST_TX_RD: begin
        a_addr = bufp;
        if (num_ff == bc_ff) begin
          nxt_txe = 1'b1;
          nxt_st = ST_WB0;
        end else begin
          nxt_st = ST_TX_LOAD;
        end
      end
      ST_TX_LOAD: begin
        nxt_txd = a_rdata;
        nxt_txv = 1'b1;
        nxt_st = ST_TX_HOLD;
      end
      ST_TX_HOLD: begin
        if (tx_ready) begin
          nxt_txv = 1'b0;
          nxt_num = num_ff + 8'h01;
          nxt_st = ST_TX_RD;
        end
      end
      ST_WB0: begin
        a_we = 1'b1;
        a_wdata = {1'b0, bd0_ff[BD_TOGGLE_BIT], pid_ff, 2'b00};
        nxt_st = ST_WB1;
      end
      ST_WB1: begin
        a_addr = base + RAM_AW'(1);
        a_we = 1'b1;
        a_wdata = num_ff;
        nxt_st = ST_DONE;
      end
      ST_DONE: begin
        int_set[INT_DONE_BIT] = 1'b1;
        nxt_stat = 8'h00;
        nxt_stat[STAT_EP_POS +: 3] = ep_ff;
        nxt_stat[STAT_DIR_POS] = dir_ff;
        nxt_stat[STAT_ODD_POS] = odd_ff;
        nxt_hsv = !dir_ff && !iso_hit;
        nxt_hsc = HS_ACK;
        err_set[ERR_BUF_BIT] = over_ff;
        nxt_st = ST_IDLE;
      end
      default: nxt_st = ST_IDLE;
    endcase
    int_set[INT_ERR_BIT] = |(err_set & err_en_ff);
  end

  // Engine registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= ST_IDLE;
      pid_ff <= 4'h0;
      ep_ff <= 3'h0;
      dir_ff <= 1'b0;
      odd_ff <= 1'b0;
      cnt_ff <= 2'h0;
      bd0_ff <= 8'h00;
      bc_ff <= 8'h00;
      adr_ff <= 6'h00;
      num_ff <= 8'h00;
      over_ff <= 1'b0;
      lat_ff <= 1'b0;
      endp_ff <= 1'b0;
      txd_ff <= 8'h00;
      txv_ff <= 1'b0;
      txe_ff <= 1'b0;
      hsv_ff <= 1'b0;
      hsc_ff <= HS_ACK;
      stat_ff <= 8'h00;
      frame_ff <= 11'h000;
    end else begin
      st_ff <= nxt_st;
      pid_ff <= nxt_pid;
      ep_ff <= nxt_ep;
      dir_ff <= nxt_dir;
      odd_ff <= nxt_odd;
      cnt_ff <= nxt_cnt;
      bd0_ff <= nxt_bd0;
      bc_ff <= nxt_bc;
      adr_ff <= nxt_adr;
      num_ff <= nxt_num;
      over_ff <= nxt_over;
      lat_ff <= nxt_lat;
      endp_ff <= nxt_endp;
      txd_ff <= nxt_txd;
      txv_ff <= nxt_txv;
      txe_ff <= nxt_txe;
      hsv_ff <= nxt_hsv;
      hsc_ff <= nxt_hsc;
      stat_ff <= nxt_stat;
      frame_ff <= nxt_frame;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  // Next state of write, read and configuration registers
  always_comb begin
    nxt_awaddr = awaddr_ff;
    nxt_araddr = araddr_ff;
    nxt_wdat = wdat_ff;
    nxt_wstb = wstb_ff;
    nxt_awf = awf_ff;
    nxt_wf = wf_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    nxt_rph = rph_ff;
    nxt_err_en = err_en_ff;
    nxt_maxp = maxp_ff;
    nxt_iso = iso_ff;
    nxt_ep_stall = ep_stall_ff;
    int_clr = '0;
    err_clr = '0;
    b_we = 1'b0;
    b_waddr = awaddr_ff[RAM_AW+1:2];
    b_wdata = wdat_ff[7:0];
    b_raddr = araddr_ff[RAM_AW+1:2];
    if (awvalid && awr_ff) begin
      nxt_awaddr = awaddr;
      nxt_awf = 1'b1;
    end
    if (wvalid && wr_ff) begin
      nxt_wdat = wdata;
      nxt_wstb = wstrb[0];
      nxt_wf = 1'b1;
    end
    if (bv_ff && bready) begin
      nxt_bv = 1'b0;
    end
    // Commit once address and data are both held
    if (awf_ff && wf_ff && !bv_ff) begin
      nxt_awf = 1'b0;
      nxt_wf = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = RESP_OKAY;
      if (awaddr_ff[RAM_BIT]) begin
        b_we = wstb_ff;
      end else if (wstb_ff) begin
        case (awaddr_ff)
          INT_STATUS_OFS: int_clr = wdat_ff[INT_W-1:0];
          ERR_STATUS_OFS: err_clr = wdat_ff[ERR_W-1:0];
          ERR_ENABLE_OFS: nxt_err_en = wdat_ff[ERR_W-1:0];
          // firmware keeps this at or below 64
          MAX_PACKET_OFS: nxt_maxp = wdat_ff[6:0];
          ISO_ENABLE_OFS: nxt_iso = wdat_ff[7:0];
          EP_STALL_OFS: nxt_ep_stall = wdat_ff[7:0];
          XFER_STATUS_OFS, FRAME_LOW_OFS, FRAME_HIGH_OFS: ;
          default: nxt_br = RESP_DECERR;
        endcase
      end else if (awaddr_ff > EP_STALL_OFS || awaddr_ff[1:0] != 2'h0) begin
        nxt_br = RESP_DECERR;
      end
    end
    // Read: address, RAM access, then answer
    if (rv_ff && rready) begin
      nxt_rv = 1'b0;
    end
    if (arvalid && arr_ff) begin
      nxt_araddr = araddr;
      nxt_rph = 2'h1;
    end else if (rph_ff == 2'h1) begin
      nxt_rph = 2'h2;
    end else if (rph_ff == 2'h2) begin
      nxt_rph = 2'h0;
      nxt_rv = 1'b1;
      nxt_rr = RESP_OKAY;
      nxt_rd = 32'h0000_0000;
      if (araddr_ff[RAM_BIT]) begin
        nxt_rd = 32'(b_rdata);
      end else begin
        case (araddr_ff)
          INT_STATUS_OFS: nxt_rd = 32'(int_flags);
          ERR_STATUS_OFS: nxt_rd = 32'(err_flags);
          ERR_ENABLE_OFS: nxt_rd = 32'(err_en_ff);
          XFER_STATUS_OFS: nxt_rd = 32'(stat_ff);
          FRAME_LOW_OFS: nxt_rd = 32'(frame_ff[7:0]);
          FRAME_HIGH_OFS: nxt_rd = 32'(frame_ff[10:8]);
          MAX_PACKET_OFS: nxt_rd = 32'(maxp_ff);
          ISO_ENABLE_OFS: nxt_rd = 32'(iso_ff);
          EP_STALL_OFS: nxt_rd = 32'(ep_stall_ff);
          default: nxt_rr = RESP_DECERR;
        endcase
      end
    end
    nxt_awr = !nxt_awf && !nxt_bv;
    nxt_wr = !nxt_wf && !nxt_bv;
    nxt_arr = (nxt_rph == 2'h0) && !nxt_rv;
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_ff <= '0;
      araddr_ff <= '0;
      wdat_ff <= 32'h0000_0000;
      wstb_ff <= 1'b0;
      awf_ff <= 1'b0;
      wf_ff <= 1'b0;
      awr_ff <= 1'b0;
      wr_ff <= 1'b0;
      bv_ff <= 1'b0;
      br_ff <= RESP_OKAY;
      arr_ff <= 1'b0;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      rr_ff <= RESP_OKAY;
      rph_ff <= 2'h0;
      err_en_ff <= ERR_EN_RESET;
      maxp_ff <= MAXP_RESET;
      iso_ff <= 8'h00;
      ep_stall_ff <= 8'h00;
    end else begin
      awaddr_ff <= nxt_awaddr;
      araddr_ff <= nxt_araddr;
      wdat_ff <= nxt_wdat;
      wstb_ff <= nxt_wstb;
      awf_ff <= nxt_awf;
      wf_ff <= nxt_wf;
      awr_ff <= nxt_awr;
      wr_ff <= nxt_wr;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      arr_ff <= nxt_arr;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
      rph_ff <= nxt_rph;
      err_en_ff <= nxt_err_en;
      maxp_ff <= nxt_maxp;
      iso_ff <= nxt_iso;
      ep_stall_ff <= nxt_ep_stall;
    end
  end

  // Outputs straight from flops
  assign awready = awr_ff;
  assign wready = wr_ff;
  assign bvalid = bv_ff;
  assign bresp = br_ff;
  assign arready = arr_ff;
  assign rvalid = rv_ff;
  assign rdata = rd_ff;
  assign rresp = rr_ff;
  assign tx_data = txd_ff;
  assign tx_valid = txv_ff;
  assign tx_end = txe_ff;
  assign hs_valid = hsv_ff;
  assign hs_code = hsc_ff;

endmodule

// >>> rtl/usb_bd_pkg.sv
// Constants shared by the descriptor-driven USB transaction engine.
// Assumes one 100 MHz clock and a same-clock serial interface engine.
// Contract
// - Descriptor address comes from endpoint, direction and even/odd buffer.
// - Packet data moves only while the descriptor ownership bit is one.
// - On completion write descriptor back with ownership cleared.
// - On completion update transfer status and set token done flag.
// - Latency overrun answers NAK, or no handshake for isochronous endpoints.
// - Latency overrun sets bus timeout error flag, gated into error summary.
// - Latency overrun leaves descriptor untouched and token done clear.
// - Oversized non-isochronous packets are still acknowledged.
// - Oversized packets store only the first max packet size bytes.
// - Oversized packets set the buffer error flag.
// - Oversized packets write back the real token id, never all ones.
// - Oversized packets write back max packet size as byte count.
// - Requests open with SETUP plus 8-byte packet, device may handshake.
// - Optional one-direction data phase up to 64 Kbytes, then status.
// - Start of frame sets frame start flag and latches 11-bit number.
// - Descriptor: byte0 own/toggle, byte1 byte count, byte2 address 9:4.
// - Buffer address low four bits are zero, 16-byte aligned.
// - Written back token id is 0x1 OUT, 0x9 IN, 0xD SETUP.
package usb_bd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus and register map
  localparam int ADDR_W = 13;
  localparam int RAM_AW = 10;
  localparam int RAM_BIT = 12;
  localparam logic [12:0] INT_STATUS_OFS = 13'h0000;
  localparam logic [12:0] ERR_STATUS_OFS = 13'h0004;
  localparam logic [12:0] ERR_ENABLE_OFS = 13'h0008;
  localparam logic [12:0] XFER_STATUS_OFS = 13'h000C;
  localparam logic [12:0] FRAME_LOW_OFS = 13'h0010;
  localparam logic [12:0] FRAME_HIGH_OFS = 13'h0014;
  localparam logic [12:0] MAX_PACKET_OFS = 13'h0018;
  localparam logic [12:0] ISO_ENABLE_OFS = 13'h001C;
  localparam logic [12:0] EP_STALL_OFS = 13'h0020;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Flag fields and reset values
  localparam int INT_W = 3;
  localparam int INT_ERR_BIT = 0;
  localparam int INT_DONE_BIT = 1;
  localparam int INT_SOF_BIT = 2;
  localparam int ERR_W = 2;
  localparam int ERR_BUF_BIT = 0;
  localparam int ERR_TIMEOUT_BIT = 1;
  localparam int STAT_EP_POS = 4;
  localparam int STAT_DIR_POS = 3;
  localparam int STAT_ODD_POS = 2;
  localparam logic [6:0] MAXP_RESET = 7'h40;
  localparam logic [1:0] ERR_EN_RESET = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor layout and token ids
  localparam logic [9:0] TABLE_BASE = 10'h000;
  localparam int BD_OWN_BIT = 7;
  localparam int BD_TOGGLE_BIT = 6;
  localparam int BD_SYNC_BIT = 3;
  localparam int BD_STALL_BIT = 2;
  localparam int BUF_ALIGN_BITS = 4;
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hD;
  localparam logic [3:0] PID_LATENCY = 4'hF;
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FETCH = 4'h1,
    ST_DECIDE = 4'h2,
    ST_RX = 4'h3,
    ST_TX_RD = 4'h4,
    ST_TX_LOAD = 4'h5,
    ST_TX_HOLD = 4'h6,
    ST_WB0 = 4'h7,
    ST_WB1 = 4'h8,
    ST_DONE = 4'h9
  } eng_state_t;

endpackage

// >>> rtl/event_flags.sv
// Sticky event flags, one per bit, cleared by write-one-to-clear.
// Assumes set and clear pulses on the same clock.
`timescale 1ns/1ps
module event_flags #(
  parameter int W = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags
);

  logic [W-1:0] nxt_flags;

  for (genvar i = 0; i < W; i++) begin : g_bit
    assign nxt_flags[i] = set[i] | (flags[i] & ~clr[i]);
  end

  // Flag storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else begin
      flags <= nxt_flags;
    end
  end

endmodule

// >>> rtl/packet_ram.sv
// Local packet RAM holding descriptors and buffers, two ports.
// Assumes one-cycle read latency; port a write wins a same-address clash.
`timescale 1ns/1ps
module packet_ram #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  input wire logic aclk,
  input wire logic [AW-1:0] a_addr,
  input wire logic a_we,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  input wire logic [AW-1:0] b_raddr,
  output logic [DW-1:0] b_rdata,
  input wire logic b_we,
  input wire logic [AW-1:0] b_waddr,
  input wire logic [DW-1:0] b_wdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Writes then registered reads
  always_ff @(posedge aclk) begin
    if (b_we) begin
      mem[b_waddr] <= b_wdata;
    end
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_raddr];
  end

endmodule

// >>> testbench/usb_bd_transaction_engine_sva.sv
// Port checker for the engine.
// Assumes one clock, sync active-low reset.
`timescale 1ns/1ps
module usb_bd_transaction_engine_sva
  import usb_bd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tok_valid,
  input wire logic rx_end,
  input wire logic hs_valid,
  input wire logic [1:0] hs_code
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Handshakes follow their cause
  a_ack_timing: assert property (
    hs_valid && hs_code == HS_ACK |-> $past(rx_end, 4))
    else $error("ACK timing");
  a_nak_cause: assert property (
    hs_valid && hs_code == HS_NAK |-> $past(rx_end) || $past(tok_valid, 6))
    else $error("NAK cause");
  a_hs_single: assert property (hs_valid |=> !hs_valid)
    else $error("HS too long");
  a_tx_held: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("IN byte lost");
  // Bus answers stand until taken
  a_b_held: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("B dropped");
  a_r_latency: assert property (arvalid && arready |-> ##3 rvalid)
    else $error("Read answer late");
  a_r_held: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("R dropped");
  a_ar_busy: assert property (rvalid |-> !arready)
    else $error("AR while busy");
  c_ack: cover property (hs_valid && hs_code == HS_ACK);
  c_nak: cover property (hs_valid && hs_code == HS_NAK);
  c_in: cover property (tx_valid && tx_ready);
endmodule

bind usb_bd_transaction_engine usb_bd_transaction_engine_sva
  i_usb_bd_transaction_engine_sva (.*);

// >>> testbench/usb_host_model.sv
// Host model: tokens, data, frame starts; sinks IN bytes.
// Assumes rising-edge sampling.
`timescale 1ns/1ps
module usb_host_model (
  input wire logic aclk,
  output logic tok_valid,
  output logic [3:0] tok_pid,
  output logic [2:0] tok_ep,
  output logic tok_odd,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic sof_valid,
  output logic [10:0] sof_frame
);
  logic [7:0] rxq[$];
  logic [7:0] txq[$];

  initial begin
    {tok_valid, tok_pid, tok_ep, tok_odd, rx_valid, rx_data} = '0;
    {rx_end, tx_ready, sof_valid, sof_frame} = '0;
  end

  // Sink stalls every other cycle
  always @(posedge aclk) begin
    tx_ready <= ~tx_ready;
    if (tx_valid === 1'h1 && tx_ready === 1'h1)
      txq.push_back(tx_data);
  end

  task automatic token(input logic [3:0] p, input logic [2:0] e,
                       input int gap, input logic fin);
    @(posedge aclk);
    tok_valid <= 1'h1;
    tok_pid <= p;
    tok_ep <= e;
    @(posedge aclk);
    tok_valid <= 1'h0;
    tok_pid <= ~p;
    repeat (gap) @(posedge aclk);
    while (rxq.size() > 0) begin
      rx_valid <= 1'h1;
      rx_data <= rxq.pop_front();
      @(posedge aclk);
      rx_valid <= 1'h0;
      rx_data <= ~rx_data;
      @(posedge aclk);
    end
    if (fin) begin
      rx_end <= 1'h1;
      @(posedge aclk);
      rx_end <= 1'h0;
    end
  endtask

  // Frame start with its number
  task automatic sof(input logic [10:0] f);
    @(posedge aclk);
    sof_valid <= 1'h1;
    sof_frame <= f;
    @(posedge aclk);
    sof_valid <= 1'h0;
    sof_frame <= ~f;
  endtask
endmodule

// >>> testbench/usb_bd_transaction_engine_tb.sv
// Engine bench: AXI4-Lite master and host model.
// Assumes the package register map.
`timescale 1ns/1ps
module usb_bd_transaction_engine_tb import usb_bd_pkg::*;;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tok_valid, tok_odd;
  logic rx_valid, rx_end, tx_valid, tx_ready, tx_end, hs_valid, sof_valid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] wstrb, tok_pid;
  logic [2:0] tok_ep;
  logic [1:0] bresp, rresp, hs_code;
  logic [7:0] rx_data, tx_data, b0, b1;
  logic [7:0] dat [8];
  logic [10:0] sof_frame, fr;
  logic [35:0] expq[$];
  int num_errors, checked, cyc;

  usb_bd_transaction_engine i_usb_bd_transaction_engine (.*);
  usb_host_model i_usb_host_model (.*);

  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [12:0] ram(input int i);
    return 13'h1000 + 13'(4 * i);
  endfunction
  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Write
  task automatic wr(input logic [12:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    expq.push_back({2'h2, r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'h1);
        awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'h1);
        wvalid <= 1'h0;
      end
    join
    bready <= 1'h1;
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [12:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    expq.push_back({2'h1, r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rready <= 1'h0;
  endtask
  task automatic arm(input int i, input logic [7:0] c, input logic [7:0] a,
                     input logic [7:0] o);
    wr(ram(i + 1), {24'h0, c});
    wr(ram(i + 2), {24'h0, a});
    wr(ram(i), {24'h0, o});
  endtask
  task automatic send(input logic [3:0] p, input logic [2:0] e, input int n,
                      input int gap, input logic fin, input logic [1:0] h);
    if (fin || n == 0) expq.push_back({2'h3, 32'h0, h});
    for (int i = 0; i < n; i++) begin
      dat[i] = xs();
      i_usb_host_model.rxq.push_back(dat[i]);
    end
    i_usb_host_model.token(p, e, gap, fin);
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (hs_valid === 1'h1 || tx_end === 1'h1) break;
    end
    repeat (4) @(posedge aclk);
  endtask
  task automatic take(input logic [35:0] s);
    if (expq.size() == 0) chk(s, ~s);
    else chk(s, expq.pop_front());
  endtask

  // Result monitor
  always @(posedge aclk) begin
    if (rvalid === 1'h1 && rready === 1'h1) take({2'h1, rresp, rdata});
    if (bvalid === 1'h1 && bready === 1'h1) take({2'h2, bresp, 32'h0});
    if (hs_valid === 1'h1) take({2'h3, 32'h0, hs_code});
  end
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h49B81BE2;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rd(INT_STATUS_OFS, 32'h0);
    rd(ERR_ENABLE_OFS, 32'h3);
    rd(MAX_PACKET_OFS, 32'h40);
    rd(13'h0FF0, 32'h0, RESP_DECERR);
    wr(13'h0FF0, 32'h1, RESP_DECERR);
    // SETUP of 8 bytes on endpoint 0
    arm(0, 8'h8, 8'h10, 8'h88);
    send(PID_SETUP, 3'h0, 8, 6, 1'h1, HS_ACK);
    rd(ram(0), 32'h34);
    rd(ram(1), 32'h8);
    for (int i = 0; i < 8; i++) rd(ram(64 + i), {24'h0, dat[i]});
    rd(XFER_STATUS_OFS, 32'h0);
    rd(INT_STATUS_OFS, 32'h2);
    rd(INT_STATUS_OFS, 32'h2);
    wr(INT_STATUS_OFS, 32'h7);
    // Oversized OUT
    wr(MAX_PACKET_OFS, 32'h4);
    wr(ram(132), 32'hA5);
    arm(12, 8'h0, 8'h20, 8'h80);
    send(PID_OUT, 3'h1, 6, 6, 1'h1, HS_ACK);
    rd(ram(12), 32'h4);
    rd(ram(13), 32'h4);
    rd(ram(131), {24'h0, dat[3]});
    rd(ram(132), 32'hA5);
    rd(ERR_STATUS_OFS, 32'h1);
    rd(XFER_STATUS_OFS, 32'h10);
    wr(ERR_STATUS_OFS, 32'h3);
    wr(INT_STATUS_OFS, 32'h7);
    // Bytes during descriptor fetch
    arm(12, 8'h0, 8'h20, 8'h80);
    send(PID_OUT, 3'h1, 3, 0, 1'h1, HS_NAK);
    rd(ram(12), 32'h80);
    rd(ERR_STATUS_OFS, 32'h2);
    rd(INT_STATUS_OFS, 32'h1);
    wr(ERR_STATUS_OFS, 32'h3);
    // Not owned
    arm(24, 8'h0, 8'h24, 8'h00);
    send(PID_OUT, 3'h2, 0, 6, 1'h0, HS_NAK);
    rd(ram(24), 32'h0);
    // IN of two bytes on endpoint 1
    b0 = xs();
    b1 = xs();
    wr(ram(80), {24'h0, b0});
    wr(ram(81), {24'h0, b1});
    wr(INT_STATUS_OFS, 32'h7);
    arm(18, 8'h2, 8'h14, 8'h80);
    i_usb_host_model.token(PID_IN, 3'h1, 6, 1'h0);
    for (int i = 0; i < 200 && tx_end !== 1'h1; i++) @(posedge aclk);
    repeat (6) @(posedge aclk);
    chk(36'(i_usb_host_model.txq.size()), 36'h2);
    chk(36'(i_usb_host_model.txq[0]), {28'h0, b0});
    chk(36'(i_usb_host_model.txq[1]), {28'h0, b1});
    rd(ram(18), 32'h24);
    rd(XFER_STATUS_OFS, 32'h18);
    wr(INT_STATUS_OFS, 32'h7);
    // Frame start
    b0 = xs();
    fr = seed[10:0];
    i_usb_host_model.sof(fr);
    repeat (2) @(posedge aclk);
    rd(FRAME_LOW_OFS, {24'h0, fr[7:0]});
    rd(FRAME_HIGH_OFS, {29'h0, fr[10:8]});
    rd(INT_STATUS_OFS, 32'h4);
    wr(INT_STATUS_OFS, 32'h4);
    rd(INT_STATUS_OFS, 32'h0);
    repeat (4) @(posedge aclk);
    chk(36'(expq.size()), 36'h0);
    report_and_stop();
  end
endmodule
